/* File: common/acsrb_pkg.sv */
// What this block does
// - Bridge switch closed while power-down pin high.
// - Link is serial clock plus data/ready line.
// - Line goes low when fresh word loaded.
// - Word is 24-bit result plus status byte.
// - Line returns high after full word read.
// - Unread word: line high before register update.
// - Each result may be read only once.
// - Conversion end resets interface, loads new word.
// - Line tristated while power-down pin low.
// - Wake 1 ms, settle first, then continuous.
// - Line high after release until first result.
// - Filter or gain change restarts, line high.
// - Settling 300 ms at 10 Hz, 120 ms otherwise.
// - Ready status bit is 0 for fresh words.
// - Error bit set for out-of-range input.
// - Status byte carries a two-bit part code.
// - Check pattern is 0 then 1.
package acsrb_pkg;
  localparam int CLK_HZ         = 40_000_000;
  localparam int CYC_PER_MS     = CLK_HZ / 1000;
  localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int WAKE_US        = 1000;
  localparam int WAKE_CYC       = WAKE_US * CLK_MHZ;
  localparam int SETTLE_10_MS   = 300;
  localparam int SETTLE_16_MS   = 120;
  localparam int PERIOD_10_MS   = 100;
  localparam int PERIOD_16_MS   = 60;
  localparam int SETTLE_10_CYC  = SETTLE_10_MS * CYC_PER_MS;
  localparam int SETTLE_16_CYC  = SETTLE_16_MS * CYC_PER_MS;
  localparam int PERIOD_10_CYC  = PERIOD_10_MS * CYC_PER_MS;
  localparam int PERIOD_16_CYC  = PERIOD_16_MS * CYC_PER_MS;
  localparam int GUARD_US       = 50;
  localparam int GUARD_CYC      = GUARD_US * CLK_MHZ;
  localparam int LSB_HOLD_NS    = 200;
  localparam int LSB_HOLD_CYC   = (LSB_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int WORD_BITS      = 32;
  localparam int RESULT_BITS    = 24;
  localparam int TIMER_W        = 24;
  localparam int CNT_W          = 6;
  localparam int HOLD_W         = 4;
  localparam int ST_RDY_POS     = 7;
  localparam int ST_FILT_POS    = 6;
  localparam int ST_ERR_POS     = 5;
  localparam int ST_ID_POS      = 3;
  localparam int ST_GAIN_POS    = 2;
  localparam int ST_PAT_POS     = 0;
  localparam logic [1:0] PAT_OK     = 2'h1;
  localparam logic       RDY_FRESH  = 1'h0;
  localparam logic [5:0] CNT_RST    = 6'h00;
  localparam logic [5:0] CNT_WORD   = 6'h20;
  localparam logic       LINE_IDLE  = 1'h1;

  typedef enum logic [1:0] {ACSRB_OFF, ACSRB_WAKE, ACSRB_SETTLE, ACSRB_RUN} acsrb_state_t;

  // Gray code keeps the counter safe to sample from the other clock.
  function automatic logic [5:0] acsrb_bin2gray(input logic [5:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [5:0] acsrb_gray2bin(input logic [5:0] g);
    logic [5:0] b;
    b = '0;
    for (int i = 5; i >= 0; i--) begin
      b[i] = (i == 5) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction
endpackage

/* File: rtl/acsrb_top.sv */
`timescale 1ns/10ps
module acsrb_top #(
  parameter int         WAKE_CYC      = acsrb_pkg::WAKE_CYC,
  parameter int         SETTLE_10_CYC = acsrb_pkg::SETTLE_10_CYC,
  parameter int         SETTLE_16_CYC = acsrb_pkg::SETTLE_16_CYC,
  parameter int         PERIOD_10_CYC = acsrb_pkg::PERIOD_10_CYC,
  parameter int         PERIOD_16_CYC = acsrb_pkg::PERIOD_16_CYC,
  parameter int         GUARD_CYC     = acsrb_pkg::GUARD_CYC,
  // Part code value is arbitrary.
  parameter logic [1:0] PART_CODE     = 2'h2
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Serial link
  input  wire logic        sclk,
  output logic             dout_o,
  output logic             dout_oe_n,
  // Control pins
  input  wire logic        powerdown_reset_pin,
  input  wire logic        filter_sel_pin,
  input  wire logic        gain_sel_pin,
  // Converter front end
  input  wire logic [23:0] conv_result,
  input  wire logic        conv_err,
  output logic             bridge_switch,
  output logic             frontend_restart,
  output logic             conv_load
);

  // Link-side bit counter.
  logic [5:0] scnt_reg;
  logic [5:0] scnt_next;
  logic [5:0] sgray_reg;

  // Pin synchronisers.
  logic pd_s1, pd_s2, filt_s1, filt_s2, gain_s1, gain_s2;
  logic filt_q, gain_q;
  logic [5:0] g_s1, g_s2;

  // Sequencer and readout state.
  acsrb_pkg::acsrb_state_t state_reg;
  logic [23:0] timer_reg;
  logic [31:0] word_reg;
  logic [5:0]  base_reg;
  logic        have_data_reg;
  logic [3:0]  hold_reg;
  logic [5:0]  sclk_cnt;
  logic [5:0]  diff;
  logic        cfg_change;
  logic        end_evt;
  logic        guard_hit;
  logic        read_done;
  logic [4:0]  bit_idx;

  // One count per falling serial clock edge; each edge presents the next bit.
  assign scnt_next = scnt_reg + 6'h01;
  // The serial clock stands still between frames, so a reset clocked by it
  // would never take effect; reset clears the count without waiting for it.
  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      scnt_reg  <= acsrb_pkg::CNT_RST;
      sgray_reg <= acsrb_pkg::CNT_RST;
    end else begin
      scnt_reg  <= scnt_next;
      sgray_reg <= acsrb_pkg::acsrb_bin2gray(scnt_next);
    end
  end

  // Two flip-flops on every pin and on the gray count.
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_s1   <= 1'h0;
      pd_s2   <= 1'h0;
      filt_s1 <= 1'h0;
      filt_s2 <= 1'h0;
      gain_s1 <= 1'h0;
      gain_s2 <= 1'h0;
      g_s1    <= acsrb_pkg::CNT_RST;
      g_s2    <= acsrb_pkg::CNT_RST;
    end else begin
      pd_s1   <= powerdown_reset_pin;
      pd_s2   <= pd_s1;
      filt_s1 <= filter_sel_pin;
      filt_s2 <= filt_s1;
      gain_s1 <= gain_sel_pin;
      gain_s2 <= gain_s1;
      g_s1    <= sgray_reg;
      g_s2    <= g_s1;
    end
  end

  // Previous pin levels for change detection.
  always_ff @(posedge clk) begin
    if (reset) begin
      filt_q <= 1'h0;
      gain_q <= 1'h0;
    end else begin
      filt_q <= filt_s2;
      gain_q <= gain_s2;
    end
  end

  // Bits consumed since the last load are the count relative to the base.
  assign sclk_cnt   = acsrb_pkg::acsrb_gray2bin(g_s2);
  assign diff       = sclk_cnt - base_reg;
  assign cfg_change = pd_s2 && (state_reg != acsrb_pkg::ACSRB_OFF) &&
                      ((filt_s2 != filt_q) || (gain_s2 != gain_q));
  assign end_evt    = pd_s2 && !cfg_change && (timer_reg == 24'h000000) &&
                      ((state_reg == acsrb_pkg::ACSRB_SETTLE) ||
                       (state_reg == acsrb_pkg::ACSRB_RUN));
  assign guard_hit  = (state_reg == acsrb_pkg::ACSRB_RUN) && have_data_reg &&
                      (diff == acsrb_pkg::CNT_RST) && (timer_reg < 24'(GUARD_CYC));
  assign read_done  = have_data_reg && (diff >= acsrb_pkg::CNT_WORD) &&
                      (hold_reg == 4'(acsrb_pkg::LSB_HOLD_CYC - 1));
  assign bit_idx    = 5'(acsrb_pkg::CNT_WORD - diff);

  // Conversion sequencer: wake, settle once, then one word per period.
  always_ff @(posedge clk) begin
    if (reset || !pd_s2) begin
      state_reg <= acsrb_pkg::ACSRB_OFF;
      timer_reg <= '0;
    end else if (cfg_change) begin
      state_reg <= acsrb_pkg::ACSRB_SETTLE;
      timer_reg <= filt_s2 ? 24'(SETTLE_10_CYC - 1) : 24'(SETTLE_16_CYC - 1);
    end else begin
      unique case (state_reg)
        acsrb_pkg::ACSRB_OFF: begin
          state_reg <= acsrb_pkg::ACSRB_WAKE;
          timer_reg <= 24'(WAKE_CYC - 1);
        end
        acsrb_pkg::ACSRB_WAKE: begin
          if (timer_reg == 24'h000000) begin
            state_reg <= acsrb_pkg::ACSRB_SETTLE;
            timer_reg <= filt_s2 ? 24'(SETTLE_10_CYC - 1) : 24'(SETTLE_16_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 24'h000001;
          end
        end
        acsrb_pkg::ACSRB_SETTLE, acsrb_pkg::ACSRB_RUN: begin
          if (timer_reg == 24'h000000) begin
            state_reg <= acsrb_pkg::ACSRB_RUN;
            timer_reg <= filt_s2 ? 24'(PERIOD_10_CYC - 1) : 24'(PERIOD_16_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 24'h000001;
          end
        end
      endcase
    end
  end

  // Every conversion end loads the word and rebases the bit count.
  // Rebasing cuts off a transfer still in progress, as the host is warned.
  always_ff @(posedge clk) begin
    if (reset) begin
      word_reg <= '0;
      base_reg <= acsrb_pkg::CNT_RST;
    end else if (end_evt) begin
      word_reg[31:8] <= conv_result;
      word_reg[acsrb_pkg::ST_RDY_POS]  <= acsrb_pkg::RDY_FRESH;
      word_reg[acsrb_pkg::ST_FILT_POS] <= filt_s2;
      word_reg[acsrb_pkg::ST_ERR_POS]  <= conv_err;
      word_reg[acsrb_pkg::ST_ID_POS +: 2]  <= PART_CODE;
      word_reg[acsrb_pkg::ST_GAIN_POS] <= gain_s2;
      word_reg[acsrb_pkg::ST_PAT_POS +: 2] <= acsrb_pkg::PAT_OK;
      base_reg <= sclk_cnt;
    end
  end

  // Word availability; a fresh load wins over a guard_hit or read_done clear in the same cycle, but reset still clears.
  always_ff @(posedge clk) begin
    if (reset || !pd_s2 || cfg_change) begin
      have_data_reg <= 1'h0;
    end else if (end_evt) begin
      have_data_reg <= 1'h1;
    end else if (guard_hit || read_done) begin
      have_data_reg <= 1'h0;
    end
  end

  // The last bit is held long enough for the host's next rising edge.
  always_ff @(posedge clk) begin
    if (reset || end_evt || !have_data_reg || (diff < acsrb_pkg::CNT_WORD)) begin
      hold_reg <= '0;
    end else if (!read_done) begin
      hold_reg <= hold_reg + 4'h1;
    end
  end

  // Data/ready line, its enable and the bridge switch.
  always_ff @(posedge clk) begin
    if (reset) begin
      dout_o        <= acsrb_pkg::LINE_IDLE;
      dout_oe_n     <= 1'h1;
      bridge_switch <= 1'h0;
    end else begin
      dout_oe_n     <= !pd_s2;
      bridge_switch <= pd_s2;
      if (!pd_s2 || !have_data_reg || cfg_change || read_done) begin
        dout_o <= acsrb_pkg::LINE_IDLE;
      end else if (diff == acsrb_pkg::CNT_RST) begin
        dout_o <= 1'h0;
      end else if (diff >= acsrb_pkg::CNT_WORD) begin
        dout_o <= word_reg[0];
      end else begin
        dout_o <= word_reg[bit_idx];
      end
    end
  end

  // Front-end strobes: filter restart and result capture.
  always_ff @(posedge clk) begin
    if (reset) begin
      frontend_restart <= 1'h0;
      conv_load        <= 1'h0;
    end else begin
      frontend_restart <= cfg_change;
      conv_load        <= end_evt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_switch_follows_pin: assert property (
    pd_s2 |=> bridge_switch && !dout_oe_n)
    else $error("Bridge switch does not follow power-down pin.");

  chk_switch_open_pd: assert property (
    !pd_s2 |=> !bridge_switch && dout_oe_n)
    else $error("Switch closed or line driven in power-down.");

  chk_tristate_pd: assert property (
    $fell(pd_s2) |-> ##1 dout_oe_n [*3])
    else $error("Line not tristated after power-down.");

  chk_ready_after_load: assert property (
    end_evt ##1 (diff == acsrb_pkg::CNT_RST && pd_s2 && !cfg_change) |=> !dout_o)
    else $error("Line not low after a fresh load.");

  chk_high_after_read: assert property (
    read_done && !end_evt |=> dout_o && !have_data_reg)
    else $error("Line not high after full word read.");

  chk_guard_high: assert property (
    guard_hit && !end_evt |=> !have_data_reg ##1 dout_o)
    else $error("Line not raised before register update.");

  chk_single_read: assert property (
    $rose(have_data_reg) |-> $past(end_evt))
    else $error("Word offered again without a new conversion.");

  chk_restart_high: assert property (
    cfg_change |=> dout_o && frontend_restart && !have_data_reg &&
                   state_reg == acsrb_pkg::ACSRB_SETTLE)
    else $error("Config change did not restart and force line high.");

  chk_status_byte: assert property (
    end_evt |=> word_reg[1:0] == 2'h1 && !word_reg[7] && word_reg[4:3] == PART_CODE)
    else $error("Status byte malformed after load.");

  chk_wake_to_settle: assert property (
    state_reg == acsrb_pkg::ACSRB_WAKE && timer_reg == 24'h000000 && pd_s2 && !cfg_change
    |=> state_reg == acsrb_pkg::ACSRB_SETTLE &&
        timer_reg == (filt_s2 ? 24'(SETTLE_10_CYC - 1) : 24'(SETTLE_16_CYC - 1)))
    else $error("Settling not started after wake time.");

  chk_no_data_before_first: assert property (
    state_reg != acsrb_pkg::ACSRB_RUN && !end_evt |=> !have_data_reg || $past(have_data_reg))
    else $error("Data offered before the first conversion.");

endmodule

/* File: sim/acsrb_host.sv */
`timescale 1ns/10ps
// Host side of the two-wire link; its serial clock stands high between frames.
module acsrb_host (
  // Link
  output logic      sclk,
  input  wire logic dout_line
);
  // The clock idles high so a frame starts with a falling edge.
  initial sclk = 1'h1;
  // One frame of 32 pulses, sampled on rising edges, short enough to end before the next load.
  task automatic read_word(output logic [31:0] w);
    w = '0;
    repeat (32) begin
      sclk = 1'h0;
      #80;
      sclk = 1'h1;
      w = {w[30:0], dout_line};
      #80;
    end
  endtask
endmodule

/* File: sim/test_acsrb_top.sv */
`timescale 1ns/10ps
module test_acsrb_top;
  localparam logic [1:0] PC = 2'h2; // Part code value is arbitrary.
  localparam int S10 = 1200;
  localparam int S16 = 600;
  logic clk, reset, sclk, dout_o, dout_oe_n, pdr, filt, gain, err, brs, rst_p, load;
  logic [23:0] res;
  logic [31:0] w;
  int err_total, checked, n, k;
  wire dout_line = dout_oe_n ? 1'bz : dout_o;

  acsrb_top #(.WAKE_CYC(20), .SETTLE_10_CYC(S10), .SETTLE_16_CYC(S16), .PERIOD_10_CYC(1000),
    .PERIOD_16_CYC(800), .GUARD_CYC(10), .PART_CODE(PC)) u_acsrb_top (
    .clk(clk), .reset(reset), .sclk(sclk), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .powerdown_reset_pin(pdr), .filter_sel_pin(filt), .gain_sel_pin(gain),
    .conv_result(res), .conv_err(err), .bridge_switch(brs), .frontend_restart(rst_p),
    .conv_load(load));
  acsrb_host u_acsrb_host (.sclk(sclk), .dout_line(dout_line));

  // The clock runs at 40 MHz.
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Every comparison goes through here so that counts stay in one place.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Bounded wait for a line level; the count is the number of clk cycles taken.
  task automatic wait_dout(input logic lvl, output int c);
    c = 0;
    while (dout_line !== lvl && c < 4000) begin
      @(negedge clk);
      c++;
    end
    chk("wait", 1, c < 4000);
  endtask

  function automatic logic [31:0] word(input logic [23:0] r, input logic f, e, g);
    return {r, 1'h0, f, e, PC, g, 2'h1};
  endfunction

  task automatic end_of_test;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A word is waiting when the pins move; the line must go high and stay so for the settle.
  task automatic cfg_change(input logic f, g, e, input logic [23:0] r, input int st);
    logic seen;
    wait_dout(1'h0, n);
    @(negedge clk);
    filt = f;
    gain = g;
    err = e;
    res = r;
    seen = 1'h0;
    repeat (6) begin
      @(negedge clk);
      seen |= rst_p;
    end
    chk("restart", 1, seen);
    chk("forced_high", 1, dout_line);
    u_acsrb_host.read_word(w);
    chk("ones", 32'hFFFFFFFF, w);
    wait_dout(1'h0, n);
    chk("settle", 1, n + 211 >= st && n + 211 <= st + 12);
    u_acsrb_host.read_word(w);
    chk("word", word(r, f, e, g), w);
  endtask

  // Main sequence.
  initial begin
    err_total = 0;
    checked = 0;
    reset = 1'h1;
    pdr = 1'h0;
    filt = 1'h1;
    gain = 1'h1;
    err = 1'h0;
    res = 24'hA5C3E1;
    repeat (20) @(negedge clk);
    reset = 1'h0;
    repeat (5) @(negedge clk);
    chk("switch_off", 0, brs);
    chk("tristate", 1, dout_line === 1'bz);
    pdr = 1'h1;
    repeat (5) @(negedge clk);
    chk("switch_on", 1, brs);
    chk("wake_high", 1, dout_line);
    wait_dout(1'h0, n);
    chk("first", 1, n >= S10 + 15 && n <= S10 + 30);
    u_acsrb_host.read_word(w);
    chk("word", word(24'hA5C3E1, 1, 0, 1), w);
    repeat (12) @(negedge clk);
    chk("done_high", 1, dout_line);
    u_acsrb_host.read_word(w);
    chk("reread", 32'hFFFFFFFF, w);
    cfg_change(1'h1, 1'h0, 1'h1, 24'h3C0F81, S10);
    cfg_change(1'h0, 1'h0, 1'h0, 24'h00FFFE, S16);
    res = 24'h7E0001;
    wait_dout(1'h0, n);
    wait_dout(1'h1, n);
    k = 0;
    while (!load && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk("guard", 1, k >= 8 && k <= 13);
    wait_dout(1'h0, n);
    u_acsrb_host.read_word(w);
    chk("reload", word(24'h7E0001, 0, 0, 0), w);
    pdr = 1'h0;
    repeat (6) @(negedge clk);
    chk("pd_tristate", 1, dout_line === 1'bz);
    chk("pd_switch", 0, brs);
    end_of_test;
  end

  // A hang is cut off well beyond the expected span of the run.
  initial begin
    #800_000;
    err_total++;
    end_of_test;
  end
endmodule
